//--- inc/drive_aux_pkg.sv
// constants, register map and carrier types of the auxiliary supervisor
package drive_aux_pkg;
   // time base: 0.1 s ticks, 0.1 min = 60 ticks
   localparam int CLK_PERIOD_NS = 40;
   localparam int TENTH_S_NS = 100_000_000;
   localparam int TENTH_S_CYCLES = TENTH_S_NS / CLK_PERIOD_NS;
   localparam int TENTHS_PER_TENTH_MIN = 60;
   // register byte offsets
   localparam logic [7:0] A_LEVEL1 = 8'h00;
   localparam logic [7:0] A_BAND1 = 8'h04;
   localparam logic [7:0] A_LEVEL2 = 8'h08;
   localparam logic [7:0] A_BAND2 = 8'h0c;
   localparam logic [7:0] A_CTRL = 8'h10;
   localparam logic [7:0] A_DURATION = 8'h14;
   localparam logic [7:0] A_AI_LOW = 8'h18;
   localparam logic [7:0] A_AI_HIGH = 8'h1c;
   localparam logic [7:0] A_TEMP_THR = 8'h20;
   localparam logic [7:0] A_WAKE_FREQ = 8'h24;
   localparam logic [7:0] A_WAKE_DELAY = 8'h28;
   localparam logic [7:0] A_SLEEP_FREQ = 8'h2c;
   localparam logic [7:0] A_SLEEP_DELAY = 8'h30;
   localparam logic [7:0] A_RUN_TARGET = 8'h34;
   localparam logic [7:0] A_MAX_FREQ = 8'h38;
   localparam logic [7:0] A_REMAINING = 8'h3c;
   localparam logic [7:0] A_STATUS = 8'h40;
   localparam logic [7:0] A_IRQ_STATUS = 8'h44;
   localparam logic [7:0] A_IRQ_MASK = 8'h48;
   // control register fields
   localparam int F_TIMING_EN = 0;
   localparam int F_SRC_LO = 1;
   localparam int F_PID_DORMANT = 4;
   localparam int F_FAN_MODE = 8;
   // limits and defaults (current 0.1 %, volts 0.01 V, time 0.1 min / 0.1 s, freq 0.01 Hz)
   localparam logic [15:0] CUR_MAX = 16'h0bb8;
   localparam logic [15:0] LEVEL_RST = 16'h03e8;
   localparam logic [15:0] TIME_MAX = 16'hfde8;
   localparam logic [15:0] AI_FULL = 16'h03e8;
   localparam logic [15:0] AI_LOW_RST = 16'h0136;
   localparam logic [15:0] AI_HIGH_RST = 16'h02a8;
   localparam logic [7:0] TEMP_MAX = 8'h64;
   localparam logic [7:0] TEMP_THR_RST = 8'h4b;
   localparam logic [7:0] FAN_TEMP = 8'h28;
   localparam logic [15:0] MAX_FREQ_RST = 16'h1388;
   localparam logic [31:0] CTRL_RST = 32'h0000_0010;

   typedef enum logic [1:0] {
      SRC_FIXED = 2'b00,
      SRC_AI_ONE = 2'b01,
      SRC_AI_TWO = 2'b10,
      SRC_RSVD = 2'b11
   } timing_src_e;

   typedef enum logic [1:0] {
      S_RUN = 2'b00,
      S_SLEEP_WAIT = 2'b01,
      S_DORMANT = 2'b10,
      S_WAKE_WAIT = 2'b11
   } sleep_state_e;

   typedef struct packed {
      logic [15:0] output_current;
      logic [15:0] set_frequency;
      logic [15:0] analog_input_one;
      logic [15:0] analog_input_two;
      logic [7:0] heatsink_temp;
   } meas_s;

   // bit order also used by status and irq registers
   typedef struct packed {
      logic run_time_reached;
      logic dormant;
      logic fan_on;
      logic temp_reached;
      logic analog_limit;
      logic timer_done;
      logic current_two;
      logic current_one;
   } dout_s;
endpackage

//--- rtl/drive_aux_supervisor.sv
// auxiliary supervision of a motor drive: current windows, timers, limits, fan, sleep
//
// Summary of operation
// - a current output is on while current lies within level plus or minus band
// - two independent current detectors, each with own level, band and output
// - levels and bands accept 0 to 300.0 %; levels reset 100.0 %, bands 0
// - with timing enabled the timer runs from start; expiry stops drive, sets output
// - duration from fixed setting, analog one or two; full scale equals fixed setting
// - timer restarts from zero at every start; remaining time is readable
// - analog limit output on while analog one is above upper or below lower limit
// - temperature output on when heatsink reaches threshold, 0 to 100, default 75
// - fan mode 0: fan on while running, or stopped and heatsink above 40 C
// - fan mode 1: fan runs continuously while selected; reset selects fan mode 0
// - running with set frequency at or below sleep level: dormant after sleep delay
// - dormant with run command and frequency at or above wake: run after wake delay
// - sleep and wake disabled when both frequencies are zero
// - wake between sleep and maximum, sleep 0 to wake, delays 0 to 6500.0 s
// - a setting selects whether regulation continues while dormant
// - run time output on once current running time reaches target
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module drive_aux_supervisor
   import drive_aux_pkg::*;
#(
   parameter int TICK_CYCLES = TENTH_S_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire meas_s meas,
   input wire logic run_command,
   input wire logic drive_running,
   output dout_s dout,
   output logic stop_request,
   output logic pid_in_dormant,
   output logic irq
);
   if (TICK_CYCLES < 1) begin : g_bad_tick
      $error("TICK_CYCLES must be at least one");
   end

   logic [15:0] level [2];
   logic [15:0] band [2];
   logic [31:0] ctrl;
   logic [15:0] duration, ai_low, ai_high, wake_freq, wake_delay, sleep_freq, sleep_delay;
   logic [15:0] run_target, max_freq, eff_duration, run_elapsed, delay_cnt;
   logic [7:0] temp_thr, irq_status, irq_mask, irq_set;
   logic [31:0] prescale;
   logic [5:0] min_div;
   logic tick, tick_min, run_cmd_d, timer_expired;
   logic [1:0] in_band;
   sleep_state_e state;
   dout_s prev;

   // upper address bits must be clear, otherwise a write would alias a register
   wire wr = psel & penable & pwrite & (paddr[31:8] == 24'h000000);
   wire setup = psel & ~penable;
   wire [7:0] a = paddr[7:0];
   wire [15:0] wd = pwdata[15:0];
   wire start_event = run_command & ~run_cmd_d;
   wire sleep_enabled = (wake_freq != 16'h0000) | (sleep_freq != 16'h0000);

   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi);
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   // register writes clamp to the legal range instead of refusing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level[0] <= LEVEL_RST;
         level[1] <= LEVEL_RST;
         band[0] <= 16'h0000;
         band[1] <= 16'h0000;
         ctrl <= CTRL_RST;
         duration <= 16'h0000;
         ai_low <= AI_LOW_RST;
         ai_high <= AI_HIGH_RST;
         temp_thr <= TEMP_THR_RST;
         wake_freq <= 16'h0000;
         wake_delay <= 16'h0000;
         sleep_freq <= 16'h0000;
         sleep_delay <= 16'h0000;
         run_target <= 16'h0000;
         max_freq <= MAX_FREQ_RST;
         irq_mask <= 8'h00;
      end else if (wr) begin
         unique case (a)
            A_LEVEL1: level[0] <= clamp(wd, 16'h0000, CUR_MAX);
            A_BAND1: band[0] <= clamp(wd, 16'h0000, CUR_MAX);
            A_LEVEL2: level[1] <= clamp(wd, 16'h0000, CUR_MAX);
            A_BAND2: band[1] <= clamp(wd, 16'h0000, CUR_MAX);
            A_CTRL: ctrl <= pwdata & 32'h0000_0117;
            A_DURATION: duration <= clamp(wd, 16'h0000, TIME_MAX);
            A_AI_LOW: ai_low <= clamp(wd, 16'h0000, ai_high);
            A_AI_HIGH: ai_high <= clamp(wd, ai_low, AI_FULL);
            A_TEMP_THR: temp_thr <= (pwdata[7:0] > TEMP_MAX) ? TEMP_MAX : pwdata[7:0];
            A_WAKE_FREQ: wake_freq <= clamp(wd, sleep_freq, max_freq);
            A_WAKE_DELAY: wake_delay <= clamp(wd, 16'h0000, TIME_MAX);
            A_SLEEP_FREQ: sleep_freq <= clamp(wd, 16'h0000, wake_freq);
            A_SLEEP_DELAY: sleep_delay <= clamp(wd, 16'h0000, TIME_MAX);
            A_RUN_TARGET: run_target <= clamp(wd, 16'h0000, TIME_MAX);
            A_MAX_FREQ: max_freq <= (wd < wake_freq) ? wake_freq : wd;
            A_IRQ_MASK: irq_mask <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // answer is prepared in the setup cycle so that prdata comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (setup) begin
            pslverr <= (a > A_IRQ_MASK) | (a[1:0] != 2'b00) | (paddr[31:8] != 24'h000000);
            prdata <= 32'h0000_0000;
            unique case (a)
               A_LEVEL1: prdata[15:0] <= level[0];
               A_BAND1: prdata[15:0] <= band[0];
               A_LEVEL2: prdata[15:0] <= level[1];
               A_BAND2: prdata[15:0] <= band[1];
               A_CTRL: prdata <= ctrl;
               A_DURATION: prdata[15:0] <= duration;
               A_AI_LOW: prdata[15:0] <= ai_low;
               A_AI_HIGH: prdata[15:0] <= ai_high;
               A_TEMP_THR: prdata[7:0] <= temp_thr;
               A_WAKE_FREQ: prdata[15:0] <= wake_freq;
               A_WAKE_DELAY: prdata[15:0] <= wake_delay;
               A_SLEEP_FREQ: prdata[15:0] <= sleep_freq;
               A_SLEEP_DELAY: prdata[15:0] <= sleep_delay;
               A_RUN_TARGET: prdata[15:0] <= run_target;
               A_MAX_FREQ: prdata[15:0] <= max_freq;
               A_REMAINING: prdata[15:0] <= (eff_duration > run_elapsed) ?
                                            eff_duration - run_elapsed : 16'h0000;
               A_STATUS: prdata[9:0] <= {state, dout};
               A_IRQ_STATUS: prdata[7:0] <= irq_status;
               A_IRQ_MASK: prdata[7:0] <= irq_mask;
               default: ;
            endcase
         end
      end
   end

   // 0.1 s tick and 0.1 min tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= 32'h0000_0000;
         min_div <= 6'h00;
         tick <= 1'b0;
         tick_min <= 1'b0;
      end else if (start_event) begin
         // realign the time base so the first 0.1 min of a run is whole
         prescale <= 32'h0000_0000;
         min_div <= 6'h00;
         tick <= 1'b0;
         tick_min <= 1'b0;
      end else begin
         tick <= (prescale == 32'(TICK_CYCLES - 1));
         prescale <= (prescale == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000 : prescale + 32'h1;
         tick_min <= tick & (min_div == 6'(TENTHS_PER_TENTH_MIN - 1));
         if (tick) begin
            min_div <= (min_div == 6'(TENTHS_PER_TENTH_MIN - 1)) ? 6'h00 : min_div + 6'h01;
         end
      end
   end

   // effective duration from the selected source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eff_duration <= 16'h0000;
      end else begin
         unique case (timing_src_e'(ctrl[F_SRC_LO +: 2]))
            SRC_AI_ONE: eff_duration <= 16'((32'(duration) * 32'(meas.analog_input_one))
                                            / 32'(AI_FULL));
            SRC_AI_TWO: eff_duration <= 16'((32'(duration) * 32'(meas.analog_input_two))
                                            / 32'(AI_FULL));
            SRC_FIXED, SRC_RSVD: eff_duration <= duration; // reserved code falls back
         endcase
      end
   end

   // running time of the present run, restarted at every start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_cmd_d <= 1'b0;
         run_elapsed <= 16'h0000;
         timer_expired <= 1'b0;
      end else begin
         run_cmd_d <= run_command;
         if (start_event) begin
            run_elapsed <= 16'h0000;
            timer_expired <= 1'b0;
         end else begin
            if (tick_min && drive_running && run_elapsed != 16'hffff) begin
               run_elapsed <= run_elapsed + 16'h0001;
            end
            if (ctrl[F_TIMING_EN] && run_command && run_elapsed >= eff_duration) begin
               timer_expired <= 1'b1;
            end
         end
      end
   end

   // sleep and wake sequencing, delays counted in 0.1 s
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_RUN;
         delay_cnt <= 16'h0000;
      end else if (!sleep_enabled) begin
         state <= S_RUN;
         delay_cnt <= 16'h0000;
      end else begin
         if (tick && delay_cnt != 16'hffff) begin
            delay_cnt <= delay_cnt + 16'h0001;
         end
         unique case (state)
            S_RUN: begin
               if (drive_running && meas.set_frequency <= sleep_freq) begin
                  state <= S_SLEEP_WAIT;
                  delay_cnt <= 16'h0000;
               end
            end
            S_SLEEP_WAIT: begin
               if (meas.set_frequency > sleep_freq || !drive_running) begin
                  state <= S_RUN;
               end else if (delay_cnt >= sleep_delay) begin
                  state <= S_DORMANT;
               end
            end
            S_DORMANT: begin
               if (!run_command) begin
                  state <= S_RUN; // a removed run command ends the dormant state
               end else if (meas.set_frequency >= wake_freq) begin
                  state <= S_WAKE_WAIT;
                  delay_cnt <= 16'h0000;
               end
            end
            S_WAKE_WAIT: begin
               if (!run_command || meas.set_frequency < wake_freq) begin
                  state <= run_command ? S_DORMANT : S_RUN;
               end else if (delay_cnt >= wake_delay) begin
                  state <= S_RUN;
               end
            end
         endcase
      end
   end

   // window detectors for both current groups
   for (genvar g = 0; g < 2; g++) begin : g_cur
      assign in_band[g] = ({1'b0, meas.output_current} + {1'b0, band[g]} >= {1'b0, level[g]})
         && ({1'b0, meas.output_current} <= {1'b0, level[g]} + {1'b0, band[g]});
   end

   // all indications registered; levels follow their condition
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout <= '0;
         stop_request <= 1'b0;
         pid_in_dormant <= 1'b0;
      end else begin
         dout.current_one <= in_band[0];
         dout.current_two <= in_band[1];
         dout.timer_done <= timer_expired;
         dout.analog_limit <= (meas.analog_input_one > ai_high)
                            | (meas.analog_input_one < ai_low);
         dout.temp_reached <= meas.heatsink_temp >= temp_thr;
         if (ctrl[F_FAN_MODE] || drive_running) begin
            dout.fan_on <= 1'b1;
         end else if (meas.heatsink_temp > FAN_TEMP) begin
            dout.fan_on <= 1'b1;
         end else if (meas.heatsink_temp < FAN_TEMP) begin
            dout.fan_on <= 1'b0; // exactly 40 C holds the last state
         end
         dout.dormant <= (state == S_DORMANT) | (state == S_WAKE_WAIT);
         // elapsed time of the previous run is stale in the start cycle
         dout.run_time_reached <= run_command && !start_event
                                && run_elapsed >= run_target;
         stop_request <= timer_expired | (state == S_DORMANT)
                       | (state == S_WAKE_WAIT);
         pid_in_dormant <= ctrl[F_PID_DORMANT] & sleep_enabled;
      end
   end

   // sticky rising-edge events; read clears, a new set in the same cycle wins
   assign irq_set = dout & ~prev;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= '0;
         irq_status <= 8'h00;
         irq <= 1'b0;
      end else begin
         prev <= dout;
         if (psel && penable && !pwrite && a == A_IRQ_STATUS && paddr[31:8] == 24'h000000) begin
            irq_status <= irq_set;
         end else begin
            irq_status <= irq_status | irq_set;
         end
         irq <= |(irq_status & irq_mask);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_band_one;
      (meas.output_current >= level[0] - band[0] && meas.output_current <= level[0] + band[0]
       && band[0] <= level[0]) |=> dout.current_one;
   endproperty
   a_band_one: assert property (p_band_one) else $error("current window one missed");

   property p_band_two_out;
      (meas.output_current > level[1] + band[1]) |=> !dout.current_two;
   endproperty
   a_band_two_out: assert property (p_band_two_out) else $error("window two on outside");

   property p_level_range;
      level[0] <= CUR_MAX && level[1] <= CUR_MAX
      && band[0] <= CUR_MAX && band[1] <= CUR_MAX;
   endproperty
   a_level_range: assert property (p_level_range) else $error("current over range");

   property p_timer_stop;
      (ctrl[F_TIMING_EN] && run_command && !start_event && run_elapsed >= eff_duration)
         |=> ##1 (stop_request && dout.timer_done);
   endproperty
   a_timer_stop: assert property (p_timer_stop) else $error("timer expiry did not stop");

   property p_restart;
      start_event |=> (run_elapsed == 16'h0000 && !timer_expired);
   endproperty
   a_restart: assert property (p_restart) else $error("timer not restarted");

   property p_ai_limits;
      ai_low <= ai_high && ai_high <= AI_FULL;
   endproperty
   a_ai_limits: assert property (p_ai_limits) else $error("analog limits out of order");

   property p_ai_over;
      (meas.analog_input_one > ai_high) |=> dout.analog_limit;
   endproperty
   a_ai_over: assert property (p_ai_over) else $error("analog limit missed");

   property p_temp;
      (meas.heatsink_temp >= temp_thr) |=> dout.temp_reached;
   endproperty
   a_temp: assert property (p_temp) else $error("temperature output missed");

   property p_fan_off;
      (!ctrl[F_FAN_MODE] && !drive_running && meas.heatsink_temp < FAN_TEMP) |=> !dout.fan_on;
   endproperty
   a_fan_off: assert property (p_fan_off) else $error("fan left on when cool");

   property p_fan_always;
      ctrl[F_FAN_MODE] |=> dout.fan_on;
   endproperty
   a_fan_always: assert property (p_fan_always) else $error("fan off in mode one");

   property p_sleep_off;
      !sleep_enabled |=> ##1 !dout.dormant;
   endproperty
   a_sleep_off: assert property (p_sleep_off) else $error("dormant while disabled");

   property p_freq_order;
      sleep_freq <= wake_freq && wake_freq <= max_freq;
   endproperty
   a_freq_order: assert property (p_freq_order) else $error("wake and sleep misordered");

   property p_runtime;
      (run_command && !start_event && run_elapsed >= run_target) |=> dout.run_time_reached;
   endproperty
   a_runtime: assert property (p_runtime) else $error("run time output missed");

   c_dormant: cover property (state == S_SLEEP_WAIT ##1 state == S_DORMANT);
   c_wake: cover property (state == S_WAKE_WAIT ##1 state == S_RUN);
   c_timer: cover property ($rose(dout.timer_done));
   c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

//--- tb/drive_partner.sv
// drive model on the far side: runs while commanded and not told to stop
`timescale 1ns/1ps
`default_nettype none
module drive_partner (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic run_command,
   input wire logic stop_request,
   output logic drive_running
);
   // one cycle of lag, a real drive never answers at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) drive_running <= 1'b0;
      else drive_running <= run_command && !stop_request;
   end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench of the auxiliary supervisor over apb
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import drive_aux_pkg::*;
   localparam int TICK = 2;
   localparam logic [7:0] RA [8] = '{A_LEVEL1, A_BAND1, A_LEVEL2, A_DURATION, A_AI_LOW,
      A_AI_HIGH, A_TEMP_THR, A_CTRL};
   localparam logic [31:0] RV [8] = '{32'h3e8, 32'h0, 32'h3e8, 32'h0, 32'h136, 32'h2a8,
      32'h4b, 32'h10};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, err, drive_running, stop_request, pid_in_dormant, irq;
   logic run_command = 1'b0;
   meas_s meas = '0;
   dout_s dout;
   int errors = 0;
   int compares = 0;

   drive_aux_supervisor #(.TICK_CYCLES(TICK)) u_drive_aux_supervisor (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas(meas),
      .run_command(run_command), .drive_running(drive_running), .dout(dout),
      .stop_request(stop_request), .pid_in_dormant(pid_in_dormant), .irq(irq));
   drive_partner u_drive_partner (.pclk(pclk), .presetn(presetn),
      .run_command(run_command), .stop_request(stop_request),
      .drive_running(drive_running));

   always #20 pclk = ~pclk;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // only the watchdog ends a wait for pready
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // waits a bounded number of edges for one output bit
   task automatic wait_bit(input int i, input logic v, input int lim);
      int n;
      n = 0;
      while (dout[i] !== v && n < lim) begin
         n++;
         @(posedge pclk);
      end
      chk({31'h0, dout[i]}, {31'h0, v});
   endtask

   task automatic test_done;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge pclk);
      errors++;
      $display("ERROR %0t: watchdog expired", $time);
      test_done();
   end

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         apb(1'b0, RA[k], '0);
         chk(rd, RV[k]);
      end
      apb(1'b0, 8'h4c, '0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, A_LEVEL1, 32'h0fa0);
      apb(1'b0, A_LEVEL1, '0);
      chk(rd, 32'h0bb8);
      apb(1'b1, A_AI_LOW, 32'h3e8);
      apb(1'b0, A_AI_LOW, '0);
      chk(rd, 32'h2a8);
      apb(1'b1, A_AI_LOW, 32'h136);
      apb(1'b1, A_LEVEL1, 32'h3e8);
      $display("registers test done");
      apb(1'b1, A_BAND1, 32'h32);
      apb(1'b1, A_LEVEL2, 32'h1f4);
      meas.output_current <= 16'h0419;
      wait_bit(0, 1'b1, 4);
      wait_bit(1, 1'b0, 4);
      meas.output_current <= 16'h041b;
      wait_bit(0, 1'b0, 4);
      meas.output_current <= 16'h01f4;
      wait_bit(1, 1'b1, 4);
      meas.analog_input_one <= 16'h01f4;
      wait_bit(3, 1'b0, 4);
      meas.analog_input_one <= 16'h02a9;
      wait_bit(3, 1'b1, 4);
      meas.analog_input_one <= 16'h0135;
      wait_bit(3, 1'b1, 4);
      $display("current and analog test done");
      meas.heatsink_temp <= 8'h4b;
      wait_bit(4, 1'b1, 4);
      meas.heatsink_temp <= 8'h4a;
      wait_bit(4, 1'b0, 4);
      wait_bit(5, 1'b1, 4);
      meas.heatsink_temp <= 8'h27;
      wait_bit(5, 1'b0, 4);
      apb(1'b1, A_CTRL, 32'h110);
      wait_bit(5, 1'b1, 4);
      apb(1'b1, A_CTRL, 32'h10);
      wait_bit(5, 1'b0, 4);
      $display("temperature and fan test done");
      apb(1'b1, A_DURATION, 32'h64);
      meas.analog_input_one <= 16'h01f4;
      meas.analog_input_two <= 16'h00fa;
      apb(1'b1, A_CTRL, 32'h12);
      apb(1'b0, A_REMAINING, '0);
      chk(rd, 32'h32);
      apb(1'b1, A_CTRL, 32'h14);
      apb(1'b0, A_REMAINING, '0);
      chk(rd, 32'h19);
      apb(1'b1, A_CTRL, 32'h16);
      apb(1'b0, A_REMAINING, '0);
      chk(rd, 32'h64);
      apb(1'b1, A_DURATION, 32'h1);
      apb(1'b1, A_RUN_TARGET, 32'h1);
      apb(1'b1, A_IRQ_MASK, 32'h4);
      apb(1'b0, A_IRQ_STATUS, '0);
      apb(1'b1, A_CTRL, 32'h11);
      for (int r = 0; r < 2; r++) begin
         run_command <= 1'b1;
         wait_bit(2, 1'b0, 4);
         apb(1'b0, A_REMAINING, '0);
         chk(rd, 32'h1);
         wait_bit(5, 1'b1, 4);
         chk({31'h0, irq}, 32'h0);
         repeat (80) @(posedge pclk);
         wait_bit(2, 1'b0, 1);
         wait_bit(2, 1'b1, 60);
         chk({31'h0, stop_request}, 32'h1);
         wait_bit(7, 1'b1, 4);
         repeat (2) @(posedge pclk);
         chk({31'h0, irq}, 32'h1);
         apb(1'b0, A_IRQ_STATUS, '0);
         chk(rd & 32'h4, 32'h4);
         repeat (2) @(posedge pclk);
         chk({31'h0, irq}, 32'h0);
         run_command <= 1'b0;
         repeat (4) @(posedge pclk);
      end
      $display("timer test done");
      apb(1'b1, A_CTRL, 32'h10);
      apb(1'b1, A_SLEEP_FREQ, 32'h1f4);
      apb(1'b0, A_SLEEP_FREQ, '0);
      chk(rd, 32'h0);
      apb(1'b1, A_WAKE_FREQ, 32'h3e8);
      apb(1'b1, A_SLEEP_FREQ, 32'h1f4);
      apb(1'b1, A_SLEEP_DELAY, 32'h1);
      apb(1'b1, A_WAKE_DELAY, 32'h1);
      meas.set_frequency <= 16'h0bb8;
      run_command <= 1'b1;
      repeat (20) @(posedge pclk);
      wait_bit(6, 1'b0, 1);
      chk({31'h0, pid_in_dormant}, 32'h1);
      meas.set_frequency <= 16'h0190;
      wait_bit(6, 1'b1, 20);
      chk({31'h0, stop_request}, 32'h1);
      meas.set_frequency <= 16'h04b0;
      wait_bit(6, 1'b0, 20);
      apb(1'b1, A_SLEEP_FREQ, 32'h0);
      apb(1'b1, A_WAKE_FREQ, 32'h0);
      meas.set_frequency <= 16'h0000;
      repeat (20) @(posedge pclk);
      wait_bit(6, 1'b0, 1);
      chk({31'h0, pid_in_dormant}, 32'h0);
      $display("sleep test done");
      test_done();
   end
endmodule
`default_nettype wire
